// File: quad_nibble_gpio_pkg.sv
package quad_nibble_gpio_pkg;

    localparam int unsigned GROUP_COUNT = 4;
    localparam int unsigned GROUP_PINS  = 4;
    localparam int unsigned PIN_COUNT   = 16;
    localparam int unsigned BUS_WIDTH   = 16;

    // register addresses, data and control alternate per group
    localparam logic [15:0] GROUP_DATA_ADDR [0:3] = '{16'h3870, 16'h3872, 16'h3874, 16'h3876};
    localparam logic [15:0] GROUP_CTRL_ADDR [0:3] = '{16'h3871, 16'h3873, 16'h3875, 16'h3877};

    // control register fields
    localparam int unsigned BIT_OP_ENABLE_BIT     = 15;
    localparam int unsigned PIN_LEVEL_SELECT_BIT  = 14;
    localparam int unsigned MODE_WRITE_ENABLE_BIT = 13;
    localparam int unsigned DIR_SELECT_BIT        = 12;
    localparam int unsigned PIN_PICK_BITS_HIGH    = 9;
    localparam int unsigned PIN_PICK_BITS_LOW     = 8;
    localparam int unsigned DIR_PIN_SELECT_HIGH   = 3;
    localparam int unsigned DIR_PIN_SELECT_LOW    = 0;
    localparam logic [15:0] CTRL_KEPT_MASK        = 16'hF30F;

    // upper eight pins are lent to the host data lines in wide bus mode
    localparam logic [15:0] HOST_UPPER_MASK = 16'hFF00;

    localparam logic [3:0]  LATCH_RESET = 4'h0;
    localparam logic [3:0]  DIR_RESET   = 4'h0;
    localparam logic [15:0] READ_RESET  = 16'h0000;
    localparam logic [11:0] READ_PAD    = 12'h000;

endpackage

// File: quad_nibble_gpio_port.sv
// Operation
// - Four independent four-pin groups make sixteen pins; data uses low four bits.
// - Eight registers at 0x3870..0x3877, data then control for groups zero to three.
// - In host wide bus mode pins eight to fifteen are released, not driven.
// - Data store loads the output latch; one drives high, zero low.
// - Latch bits of input pins never affect any pin level.
// - Reset clears every output latch and every direction register.
// - Data load returns synchronised levels of input pins in low four bits.
// - Data load bits of output pins are undefined; here they echo the latch.
// - Control store with bit op enable forces the picked pin to given level.
// - Pin pick bits nine and eight select pin zero to three.
// - Pin level select zero drives low, one high, only with bit op enable.
// - Control store with mode write enable sets selected pins input or output.
// - Each of four direction select bits acts independently; others keep direction.
// - Control load returns current pin directions in bits three to zero.
// - Control strobe bits read back as anything; here zero.
// - Reserved control bits eleven, ten and seven to four store nothing.
// - Pin sampling and pin updates happen on the rising system clock edge.
// - Control changes reach the pins two clocks after the store.
// - Data latch value reaches the pins one clock after the store.
// - Input levels pass a two stage synchroniser before being readable.
// - Data store wins over a single pin change landing in the same cycle.
`timescale 1ns/10ps

module quad_nibble_gpio_port
    import quad_nibble_gpio_pkg::*;
(
    input  wire logic        i_mclk,       // system clock, 125 MHz
    input  wire logic        i_arst_n,     // async reset, active low
    input  wire logic [15:0] i_addr,       // peripheral bus word address
    input  wire logic [15:0] i_wdata,      // store data
    input  wire logic        i_store,      // store strobe, one cycle
    input  wire logic        i_load,       // load strobe, one cycle
    input  wire logic        i_host_wide,  // host interface in 16-bit bus mode
    input  wire logic [15:0] i_pin_in,     // pin input levels
    output logic      [15:0] o_pin_out,    // pin output levels
    output logic      [15:0] o_pin_oe,     // pin output enables, high drives
    output logic      [15:0] o_rdata,      // load data
    output logic             o_rd_valid    // load answer, one cycle
);

    logic             rst_meta_r;
    logic             rst_n;
    logic [15:0]      latch_r;
    logic [15:0]      latch_nxt;
    logic [15:0]      dir_r;
    logic [15:0]      dir_nxt;
    logic [15:0]      pin_meta_r;
    logic [15:0]      pin_sync_r;
    logic [3:0]       pend_vld_r;
    logic [3:0]       pend_vld_nxt;
    logic [15:0]      pend_cmd_r [0:3];
    logic [15:0]      pend_cmd_nxt [0:3];
    logic [3:0]       data_hit;
    logic [3:0]       ctrl_hit;
    logic [15:0]      read_data [0:3];
    logic [3:0]       read_hit;
    logic [15:0]      host_mask;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // lent pins are dropped here so they can never fight the host drivers
    assign host_mask = i_host_wide ? HOST_UPPER_MASK : 16'h0000;

    genvar g;
    generate
        for (g = 0; g < GROUP_COUNT; g++)
        begin : grp
            localparam int unsigned LO = g * GROUP_PINS;
            logic [3:0] lat;
            logic [3:0] dir;
            logic [3:0] sel;
            logic [15:0] pc;

            assign data_hit[g] = i_store && (i_addr == GROUP_DATA_ADDR[g]);
            assign ctrl_hit[g] = i_store && (i_addr == GROUP_CTRL_ADDR[g]);

            // store lands in a pending stage so control effects trail data by one clock
            assign pend_vld_nxt[g] = ctrl_hit[g];
            assign pend_cmd_nxt[g] = ctrl_hit[g] ? (i_wdata & CTRL_KEPT_MASK) : pend_cmd_r[g];

            assign pc  = pend_cmd_r[g];
            assign sel = pc[DIR_PIN_SELECT_HIGH:DIR_PIN_SELECT_LOW];

            always_comb
            begin
                lat = latch_r[LO +: 4];
                dir = dir_r[LO +: 4];
                // level change and direction change may come from one store
                if (pend_vld_r[g] && pc[BIT_OP_ENABLE_BIT])
                begin
                    lat[pc[PIN_PICK_BITS_HIGH:PIN_PICK_BITS_LOW]] = pc[PIN_LEVEL_SELECT_BIT];
                end
                if (data_hit[g])
                begin
                    lat = i_wdata[3:0];
                end
                if (pend_vld_r[g] && pc[MODE_WRITE_ENABLE_BIT])
                begin
                    dir = pc[DIR_SELECT_BIT] ? (dir | sel) : (dir & ~sel);
                end
            end

            assign latch_nxt[LO +: 4] = lat;
            assign dir_nxt[LO +: 4]   = dir;

            // output pins echo the latch; input pins show the synchronised level
            assign read_data[g] = (i_addr == GROUP_CTRL_ADDR[g]) ?
                                  {READ_PAD, dir_r[LO +: 4]} :
                                  {READ_PAD, (pin_sync_r[LO +: 4] & ~dir_r[LO +: 4]) |
                                             (latch_r[LO +: 4] & dir_r[LO +: 4])};
            assign read_hit[g]  = (i_addr == GROUP_DATA_ADDR[g]) || (i_addr == GROUP_CTRL_ADDR[g]);

            a_data_one_clk: assert property (
                (data_hit[g] && !i_host_wide) ##1 (!data_hit[g] && !i_host_wide)
                |=> (o_pin_out[LO +: 4] == ($past(i_wdata[3:0], 2) & o_pin_oe[LO +: 4])))
                else $error("data store not on pins one clock later");

            a_dir_two_clk: assert property (
                (ctrl_hit[g] && i_wdata[MODE_WRITE_ENABLE_BIT] && i_wdata[DIR_SELECT_BIT] && !i_host_wide)
                ##1 !i_host_wide ##1 !i_host_wide
                |=> ((o_pin_oe[LO +: 4] & $past(i_wdata[3:0], 3)) == $past(i_wdata[3:0], 3)))
                else $error("direction change not on pins two clocks later");

            a_dir_keep_unsel: assert property (
                ctrl_hit[g] && i_wdata[MODE_WRITE_ENABLE_BIT]
                |-> ##2 (((dir_r[LO +: 4] ^ $past(dir_r[LO +: 4])) & ~$past(i_wdata[3:0], 2)) == 4'h0))
                else $error("unselected pin changed direction");

            a_no_bit_op: assert property (
                (ctrl_hit[g] && !i_wdata[BIT_OP_ENABLE_BIT]) ##1 !data_hit[g]
                |=> (latch_r[LO +: 4] == $past(latch_r[LO +: 4])))
                else $error("pin level changed without bit op enable");

            a_bit_op_level: assert property (
                (ctrl_hit[g] && i_wdata[BIT_OP_ENABLE_BIT]) ##1 !data_hit[g]
                |=> (latch_r[LO + $past(i_wdata[9:8], 2)] == $past(i_wdata[PIN_LEVEL_SELECT_BIT], 2)))
                else $error("picked pin not forced to selected level");

            a_data_wins: assert property (
                pend_vld_r[g] && pend_cmd_r[g][BIT_OP_ENABLE_BIT] && data_hit[g]
                |=> (latch_r[LO +: 4] == $past(i_wdata[3:0])))
                else $error("bit op overrode simultaneous data store");

            a_input_sync: assert property (
                i_load && (i_addr == GROUP_DATA_ADDR[g]) && (dir_r[LO +: 4] == 4'h0)
                |=> (o_rdata == {READ_PAD, $past(i_pin_in[LO +: 4], 3)}))
                else $error("input read not two stage synchronised");

            a_ctrl_readback: assert property (
                i_load && (i_addr == GROUP_CTRL_ADDR[g])
                |=> (o_rdata == {READ_PAD, $past(dir_r[LO +: 4])}))
                else $error("control read does not show directions");

            a_ctrl_upper_zero: assert property (
                i_load && (i_addr == GROUP_CTRL_ADDR[g])
                |=> (o_rdata[15:4] == READ_PAD))
                else $error("control read strobe bits not zero");

            a_data_read_echo: assert property (
                i_load && (i_addr == GROUP_DATA_ADDR[g]) && (dir_r[LO +: 4] == 4'hF)
                |=> (o_rdata == {READ_PAD, $past(latch_r[LO +: 4])}))
                else $error("output pin read does not echo latch");

            a_reserved_dropped: assert property (
                (pend_cmd_r[g] & ~CTRL_KEPT_MASK) == 16'h0000)
                else $error("reserved control bit stored");

            // pending stage must mirror the store exactly one clock later
            a_pend_follows: assert property (
                pend_vld_r[g] == $past(ctrl_hit[g]))
                else $error("pending control stage out of step");

            a_latch_hold: assert property (
                !data_hit[g] && !(pend_vld_r[g] && pc[BIT_OP_ENABLE_BIT])
                |=> $stable(latch_r[LO +: 4]))
                else $error("latch changed without a store");

            a_dir_hold: assert property (
                !(pend_vld_r[g] && pc[MODE_WRITE_ENABLE_BIT])
                |=> $stable(dir_r[LO +: 4]))
                else $error("direction changed without mode write");
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latch_r <= {GROUP_COUNT{LATCH_RESET}};
            dir_r   <= {GROUP_COUNT{DIR_RESET}};
        end
        else
        begin
            latch_r <= latch_nxt;
            dir_r   <= dir_nxt;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_vld_r <= 4'h0;
            for (int i = 0; i < GROUP_COUNT; i++)
            begin
                pend_cmd_r[i] <= 16'h0000;
            end
        end
        else
        begin
            pend_vld_r <= pend_vld_nxt;
            for (int i = 0; i < GROUP_COUNT; i++)
            begin
                pend_cmd_r[i] <= pend_cmd_nxt[i];
            end
        end
    end

    // pins are asynchronous; the first stage feeds only the second
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= 16'h0000;
            pin_sync_r <= 16'h0000;
        end
        else
        begin
            pin_meta_r <= i_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // input pins drive zero with enable low, so a stale latch bit stays invisible
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_pin_out <= 16'h0000;
            o_pin_oe  <= 16'h0000;
        end
        else
        begin
            o_pin_out <= latch_r & dir_r & ~host_mask;
            o_pin_oe  <= dir_r & ~host_mask;
        end
    end

    // unmapped loads answer zero so software never sees stale data
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_rdata    <= READ_RESET;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_load;
            if (i_load)
            begin
                o_rdata <= READ_RESET;
                for (int i = 0; i < GROUP_COUNT; i++)
                begin
                    if (read_hit[i])
                    begin
                        o_rdata <= read_data[i];
                    end
                end
            end
        end
    end

    a_host_pins_free: assert property (
        i_host_wide |=> ((o_pin_oe & HOST_UPPER_MASK) == 16'h0000))
        else $error("upper pins driven in host wide mode");

    a_input_undriven: assert property (
        (o_pin_out & ~o_pin_oe) == 16'h0000)
        else $error("level shown on a pin that is not driven");

    a_reset_inputs: assert property (
        $rose(rst_n) |-> (o_pin_oe == 16'h0000) && (latch_r == 16'h0000))
        else $error("pins not all inputs after reset");

    a_lent_out_low: assert property (
        i_host_wide |=> ((o_pin_out & HOST_UPPER_MASK) == 16'h0000))
        else $error("upper pin level shown in host wide mode");

    // enables are one register behind direction, never combinational
    a_oe_follows: assert property (
        o_pin_oe == $past(dir_r & ~host_mask))
        else $error("pin enables not one clock behind direction");

    a_out_follows: assert property (
        o_pin_out == $past(latch_r & dir_r & ~host_mask))
        else $error("pin levels not one clock behind latch");

    // first two clocks after reset still hold reset zeros in the chain
    a_sync_chain: assert property (
        $past(rst_n, 2) |-> (pin_sync_r == $past(i_pin_in, 2)))
        else $error("input synchroniser depth wrong");

    a_load_answer: assert property (
        o_rd_valid == $past(i_load))
        else $error("load answer not one clock after load");

    a_unmapped_zero: assert property (
        i_load && (read_hit == 4'h0) |=> (o_rdata == READ_RESET))
        else $error("unmapped load did not return zero");

    // zero here rather than hold, so a stray address never leaks old data
    a_upper_read_pad: assert property (
        o_rd_valid |-> (o_rdata[15:4] == READ_PAD))
        else $error("read data above the low nibble not zero");

endmodule // quad_nibble_gpio_port

// File: ext_pin_circuit.sv
`timescale 1ns/10ps

module ext_pin_circuit
(
    input  wire logic        i_clk,      // system clock
    input  wire logic        i_slow,     // present new levels a clock late
    input  wire logic [15:0] i_drive,    // levels the circuitry presents
    input  wire logic [15:0] i_pin_out,  // device output levels
    input  wire logic [15:0] i_pin_oe,   // device drives where high
    output logic      [15:0] o_level     // resolved pin levels
);
    logic [15:0] drive_r;

    always_ff @(posedge i_clk)
    begin
        drive_r <= i_drive;
    end

    // circuitry backs off where the device drives, so no contention is modelled
    assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & (i_slow ? drive_r : i_drive));
endmodule // ext_pin_circuit

// File: testbench.sv
`timescale 1ns/10ps

module testbench;
    import quad_nibble_gpio_pkg::*;
    logic        i_mclk = 0, i_arst_n = 0, i_store = 0, i_load = 0, i_host_wide = 0, slow = 0;
    logic [15:0] i_addr = 16'h0000, i_wdata = 16'h0000, ext = 16'h0000;
    logic [15:0] i_pin_in, o_pin_out, o_pin_oe, o_rdata;
    logic        o_rd_valid;
    logic [15:0] exp_q[$];
    logic [3:0]  lat[4], dir[4];
    logic [31:0] lfsr = 32'h000165BE;
    int          bad_count = 0, n_compared = 0, cyc = 0;

    always #4 i_mclk = ~i_mclk;

    quad_nibble_gpio_port u_quad_nibble_gpio_port (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_store(i_store), .i_load(i_load), .i_host_wide(i_host_wide),
        .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_rdata(o_rdata),
        .o_rd_valid(o_rd_valid));
    ext_pin_circuit u_ext_pin_circuit (.i_clk(i_mclk), .i_slow(slow), .i_drive(ext),
        .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .o_level(i_pin_in));

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction

    function automatic void upd(logic [15:0] a, logic [15:0] d);
        if (a[15:3] == 13'h070E)
        begin
            if (!a[0])
                lat[a[2:1]] = d[3:0];
            else
            begin
                // data store in the same cycle is applied later by the caller, so it wins
                if (d[15]) lat[a[2:1]][d[9:8]] = d[14];
                for (int k = 0; k < 4; k++)
                    if (d[13] && d[k]) dir[a[2:1]][k] = d[12];
            end
        end
    endfunction

    function automatic logic [15:0] rexp(logic [15:0] a);
        if (a[15:3] != 13'h070E) return 16'h0000;
        if (a[0]) return {12'h000, dir[a[2:1]]};
        return {12'h000, (ext[{a[2:1], 2'b00} +: 4] & ~dir[a[2:1]]) | (lat[a[2:1]] & dir[a[2:1]])};
    endfunction

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_rd(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD t=%0t read got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD t=%0t pin got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic pins();
        logic [15:0] eoe;
        eoe = {dir[3], dir[2], dir[1], dir[0]};
        if (i_host_wide) eoe[15:8] = 8'h00;
        chk_pin(o_pin_oe, eoe);
        chk_pin(o_pin_out, eoe & {lat[3], lat[2], lat[1], lat[0]});
    endtask

    // called at a rising edge; checks the pins one clock after a data store, and at the first and second clock after any other store; with keep set it checks nothing
    task automatic st(input logic [15:0] a, input logic [15:0] d, input bit keep = 0);
        i_store <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        if (keep)
        begin
            upd(a, d);
            return;
        end
        i_store <= 1'b0;
        @(posedge i_mclk);
        #1;
        if (a[15:3] == 13'h070E && !a[0])
        begin
            upd(a, d);
            pins();
        end
        else
        begin
            pins();
            upd(a, d);
            @(posedge i_mclk);
            #1;
            pins();
        end
        @(posedge i_mclk);
    endtask

    task automatic ld(input logic [15:0] a);
        i_load <= 1'b1;
        i_addr <= a;
        exp_q.push_back(rexp(a));
        @(posedge i_mclk);
        i_load <= 1'b0;
        @(posedge i_mclk);
    endtask

    always @(posedge i_mclk)
    begin
        if (o_rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                bad_count++;
                $display("BAD t=%0t read got=%h exp=none", $time, o_rdata);
            end
            else
                chk_rd(o_rdata, exp_q.pop_front());
        end
    end

    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            bad_count++;
            end_sim();
        end
    end

    initial
    begin
        for (int g = 0; g < 4; g++)
        begin
            lat[g] = LATCH_RESET;
            dir[g] = DIR_RESET;
        end
        repeat (4) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        for (int a = 0; a < 9; a++) ld(16'h3870 + 16'(a));
        pins();
        st(16'h3878, 16'hFFFF);
        ld(16'h3878);
        $display("test reset and decode done");
        for (int g = 0; g < 4; g++)
        begin
            st(GROUP_DATA_ADDR[g], rnd());
            st(GROUP_CTRL_ADDR[g], 16'h3CFF);
            ld(GROUP_CTRL_ADDR[g]);
            st(GROUP_DATA_ADDR[g], rnd());
            ld(GROUP_DATA_ADDR[g]);
        end
        $display("test outputs done");
        for (int p = 0; p < 8; p++) st(GROUP_CTRL_ADDR[1], {1'b1, p[0], 4'h0, p[2:1], 8'h00});
        st(GROUP_CTRL_ADDR[1], 16'h4300);
        $display("test bit operations done");
        ext <= rnd();
        st(GROUP_CTRL_ADDR[2], 16'h2005);
        repeat (4) @(posedge i_mclk);
        ld(GROUP_DATA_ADDR[2]);
        slow <= 1'b1;
        ext  <= rnd();
        repeat (5) @(posedge i_mclk);
        ld(GROUP_DATA_ADDR[2]);
        slow <= 1'b0;
        st(GROUP_CTRL_ADDR[2], 16'hF105);
        $display("test directions and inputs done");
        st(GROUP_CTRL_ADDR[3], 16'hC200, 1);
        st(GROUP_DATA_ADDR[3], rnd());
        $display("test same cycle priority done");
        i_host_wide <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        pins();
        @(posedge i_mclk);
        st(GROUP_DATA_ADDR[3], rnd());
        ld(GROUP_CTRL_ADDR[3]);
        repeat (3) @(posedge i_mclk);
        $display("test host wide mode done");
        end_sim();
    end
endmodule // testbench
